// ---- dv/dbc_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module dbc_ctrl_tb_top;
   import dbc_pkg::*;
   logic clk;                  // Processor clock
   logic nrst;                 // Async reset, active low
   logic [31:0] addr;          // Register address
   logic [63:0] wdata;         // Write data
   logic we;                   // Write strobe
   logic re;                   // Read strobe
   logic [63:0] rdata;         // Read data
   dbc_cpu_t cpu;              // Processor events
   dbc_evt_t evt;              // Exception and trace pulses
   logic [7:0] brk_vector;     // Breakpoint vector
   logic [7:0] counter_en;     // Global counter enables
   logic [63:0] debug_ctl;     // Live control value
   int failures;               // Mismatch count
   int num_checks;             // Comparison count
   logic [63:0] rd;            // Last read value
   logic [3:0] seen;           // Record slots matched

   dbc_ctrl u_dbc_ctrl (.clk(clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .we(we), .re(re), .rdata(rdata), .cpu(cpu),
      .evt(evt), .brk_vector(brk_vector), .counter_en(counter_en),
      .debug_ctl(debug_ctl));

   // Free-running 50 ns clock
   always #25 clk = ~clk;

   // Compare a value, four-state exact
   task automatic chk(input string name, input logic [63:0] exp,
         input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One-cycle write strobe; effect is visible once it returns
   task automatic wr(input logic [31:0] a, input logic [63:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      #1;
   endtask : wr

   // One-cycle read strobe; data only stands in the following cycle
   task automatic rdr(input logic [31:0] a);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      rd = rdata;
   endtask : rdr

   // Present core events for exactly one cycle
   task automatic ev(input dbc_cpu_t c);
      @(posedge clk);
      cpu <= c;
      @(posedge clk);
      cpu <= '0;
      #1;
   endtask : ev

   // Let hardware side effects settle
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   // Verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   // Hang guard, well beyond the hundred-odd cycles of the tests
   initial begin
      #(50 * 20000);
      failures++;
      results();
   end

   // Trace filter table: control, level, expected msg, store and interrupt
   logic [63:0] t_ctl [9] = '{64'hC0, 64'h2C0, 64'h2C0, 64'h4C0,
      64'h4C0, 64'h40, 64'h80, 64'h180, 64'h80};
   logic [1:0] t_lvl [9] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h1,
      2'h2, 2'h0, 2'h0};
   logic t_msg [9] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
   logic t_sto [9] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1};
   logic t_irq [9] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};

   // Main sequence
   initial begin
      dbc_cpu_t c;
      clk = 1'b0;
      nrst = 1'b0;
      addr = '0;
      wdata = '0;
      we = 1'b0;
      re = 1'b0;
      cpu = '0;
      failures = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk("ctl_rst", 64'h0, debug_ctl);
      chk("cnt_rst", 64'h0, {56'h0, counter_en});
      rdr(DBC_ADDR_STS);
      chk("sts_rst", 64'h0, rd);
      // Fill the record stack; slots are absolute, so match by content
      wr(DBC_ADDR_CTL, 64'h1);
      for (int i = 0; i < 4; i++) begin
         c = '0;
         c.branch = (i != 1);
         c.intr = (i == 1);
         c.from = 32'h00000100 + i;
         c.to = 32'h00000200 + i;
         ev(c);
      end
      // A debug exception must leave the stack as it is
      c = '0;
      c.exc = 1'b1;
      c.exc_is_dbg = 1'b1;
      c.from = 32'h0000DEAD;
      c.to = 32'h0000BEEF;
      ev(c);
      for (int pass = 0; pass < 1; pass++) begin
         seen = '0;
         for (int s = 0; s < 4; s++) begin
            rdr(DBC_ADDR_REC + s);
            for (int j = 0; j < 4; j++) begin
               if (rd === {32'h00000200 + j, 32'h00000100 + j}) begin
                  seen[j] = 1'b1;
               end
            end
         end
         chk("rec_slots", 64'hF, {60'h0, seen});
      end
      // Register placement, implemented bits and unmapped places
      wr(DBC_ADDR_CTL, 64'hFFFFFFFFFFFFFFFF);
      rdr(DBC_ADDR_CTL);
      chk("ctl_mask", 64'h5FC3, rd);
      wr(32'h000001D8, 64'h0);
      rdr(DBC_ADDR_CTL);
      chk("ctl_unmapped_wr", 64'h5FC3, rd);
      rdr(32'h000001D8);
      chk("unmapped_rd", 64'h0, rd);
      // Trace message, store, privilege skip and buffer-full interrupt
      for (int i = 0; i < 9; i++) begin
         wr(DBC_ADDR_CTL, t_ctl[i]);
         c = '0;
         c.branch = (i % 3 == 0);
         c.intr = (i % 3 == 1);
         c.exc = (i % 3 == 2);
         c.current_privilege_level = t_lvl[i];
         c.buf_full = (i >= 7);
         ev(c);
         chk("trace_msg", 64'(t_msg[i]), 64'(evt.trace_msg));
         chk("store", 64'(t_sto[i]), 64'(evt.trace_store));
         chk("buf_irq", 64'(t_irq[i]), 64'(evt.buf_irq));
      end
      // Software breakpoint
      c = '0;
      c.brk_insn = 1'b1;
      ev(c);
      chk("brk_exc", 64'h1, {63'h0, evt.brk_exc});
      chk("brk_vec", 64'h3, {56'h0, brk_vector});
      // Branch stepping: no trap without a branch, trap with one
      wr(DBC_ADDR_CTL, 64'h43);
      c = '0;
      c.trap_step_flag = 1'b1;
      c.retire = 1'b1;
      ev(c);
      chk("step_nobr", 64'h0, {63'h0, evt.dbg_exc});
      c.branch = 1'b1;
      ev(c);
      chk("step_br", 64'h1, {63'h0, evt.dbg_exc});
      chk("step_cause", 64'h1, {63'h0, evt.cause_step});
      idle(2);
      chk("ctl_after_dbg", 64'h40, debug_ctl);
      rdr(DBC_ADDR_STS);
      chk("sts_step", 64'h1, {63'h0, rd[DBC_S_STEP]});
      wr(DBC_ADDR_STS, 64'h0);
      // Task switch into a trapped task
      wr(DBC_ADDR_CTL, 64'h1);
      c = '0;
      c.task_sw = 1'b1;
      c.task_trap = 1'b1;
      // The trapped task is never the debug handler's own task
      ev(c);
      idle(1);
      chk("tsw_exc", 64'h1, {63'h0, evt.dbg_exc});
      chk("tsw_cause", 64'h1, {63'h0, evt.cause_tsw});
      rdr(DBC_ADDR_STS);
      chk("sts_tsw", 64'h1, {63'h0, rd[DBC_S_TSW]});
      // Freeze records on a performance interrupt
      wr(DBC_ADDR_CTL, 64'h801);
      c = '0;
      c.perf_irq = 1'b1;
      ev(c);
      idle(1);
      chk("frz_rec", 64'h800, debug_ctl);
      // Freeze counters on a performance interrupt
      wr(DBC_ADDR_CNT, 64'hFF);
      chk("cnt_wr", 64'hFF, {56'h0, counter_en});
      wr(DBC_ADDR_CTL, 64'h1000);
      ev(c);
      idle(1);
      chk("frz_cnt", 64'h0, {56'h0, counter_en});
      // Management mode entry clears, resume restores control and sets every counter enable
      wr(DBC_ADDR_CNT, 64'h0F);
      wr(DBC_ADDR_CTL, 64'h41C3);
      c = '0;
      c.mgmt_irq = 1'b1;
      ev(c);
      idle(1);
      chk("mgmt_ctl", 64'h4100, debug_ctl);
      chk("mgmt_cnt", 64'h0, {56'h0, counter_en});
      c = '0;
      c.mgmt_mode_resume = 1'b1;
      ev(c);
      idle(1);
      chk("rsm_ctl", 64'h41C3, debug_ctl);
      chk("rsm_cnt", 64'hFF, {56'h0, counter_en});
      results();
   end
endmodule : dbc_ctrl_tb_top

// ---- hdl/dbc_ctrl.sv ----
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module dbc_ctrl
   import dbc_pkg::*;
(
   input wire logic clk,              // 20 MHz processor clock
   input wire logic nrst,             // Async reset, active low
   input wire logic [31:0] addr,      // Register address
   input wire logic [63:0] wdata,     // Write data
   input wire logic we,               // Write strobe
   input wire logic re,               // Read strobe
   output logic [63:0] rdata,         // Read data, cycle after re
   input wire dbc_cpu_t cpu,          // Processor event inputs
   output dbc_evt_t evt,              // Exception and trace pulses
   output logic [7:0] brk_vector,     // Vector of breakpoint pulse
   output logic [7:0] counter_en,     // Global counter enables
   output logic [63:0] debug_ctl      // Live debug control value
);
   logic [63:0] ctl_reg;          // Debug control register
   logic [63:0] ctl_next;
   logic [63:0] sts_reg;          // Debug status register
   logic [63:0] sts_next;
   logic [63:0] save_reg;         // Copy kept over management mode
   logic [63:0] save_next;
   logic [7:0] cnt_reg;           // Global counter enables
   logic [7:0] cnt_next;
   logic [63:0] rdata_reg;        // Read data holding flop
   logic [63:0] rdata_next;
   dbc_evt_t evt_reg;             // Registered pulses
   dbc_evt_t evt_next;
   logic [7:0] vec_reg;           // Registered vector
   logic frz_reg;                 // Record stack frozen
   logic frz_next;
   logic tsw_pend_reg;            // Task-switch exception pending
   dbc_mode_t mode_reg;           // Management-mode state
   dbc_mode_t mode_next;

   // Address decode
   wire wr_ctl = we && addr == DBC_ADDR_CTL;
   wire wr_sts = we && addr == DBC_ADDR_STS;
   wire wr_cnt = we && addr == DBC_ADDR_CNT;
   wire rd_rec = addr[31:2] == DBC_ADDR_REC[31:2];

   // Control field views
   wire f_rec = ctl_reg[DBC_B_REC];
   wire f_step = ctl_reg[DBC_B_STEP];
   wire f_msg = ctl_reg[DBC_B_MSG];
   wire f_store = ctl_reg[DBC_B_STORE];
   wire f_irq = ctl_reg[DBC_B_IRQ];
   wire f_skpriv = ctl_reg[DBC_B_SKPRIV];
   wire f_skusr = ctl_reg[DBC_B_SKUSR];
   wire f_frzrec = ctl_reg[DBC_B_FRZREC];
   wire f_frzcnt = ctl_reg[DBC_B_FRZCNT];
   wire f_mgmt = ctl_reg[DBC_B_MGMT];

   // Any control transfer the trace logic sees
   wire xfer = cpu.branch || cpu.intr || cpu.exc;
   // Debug exceptions alone are kept out of the stack
   wire xfer_rec = cpu.branch || cpu.intr ||
                   (cpu.exc && !cpu.exc_is_dbg);
   // Stack updates while records or messages need it
   wire rec_on = (f_rec || f_msg) && !frz_reg;
   wire rec_push = xfer_rec && rec_on;

   // Privilege filter applies to both messages and stores
   wire lvl0 = cpu.current_privilege_level == 2'h0;
   wire skip = (f_skpriv && lvl0) ||
               (f_skusr && !lvl0);
   wire msg_hit = xfer && f_msg && !skip;
   wire store_hit = xfer && f_store && !skip;
   // Without the interrupt bit the buffer simply wraps
   wire full_irq = store_hit && f_irq && cpu.buf_full;

   // Task switches never count as a stepped branch
   wire step_hit = cpu.trap_step_flag && cpu.retire && !cpu.task_sw &&
                   (!f_step || cpu.branch);
   wire tsw_hit = cpu.task_sw && cpu.task_trap;
   // Pending task exception lands before the first instruction
   wire dbg_fire = tsw_pend_reg || step_hit;

   wire perf_rec = cpu.perf_irq && f_frzrec;
   wire perf_cnt = cpu.perf_irq && f_frzcnt;
   wire mgmt_in = cpu.mgmt_irq && f_mgmt && mode_reg == DBC_RUN;
   wire mgmt_out = cpu.mgmt_mode_resume && mode_reg == DBC_MGMT;

   // Record stack read
   logic [63:0] rec_data;
   logic [1:0] rec_tos;

   dbc_rec_stack u_rec (
      .clk(clk),
      .nrst(nrst),
      .push(rec_push),
      .from(cpu.from),
      .to(cpu.to),
      .rd_idx(addr[1:0]),
      .rd_data(rec_data),
      .tos(rec_tos)
   );

   // Read mux; the stack stays readable after an exception
   wire [63:0] rd_mux =
      (addr == DBC_ADDR_CTL) ? ctl_reg :
      (addr == DBC_ADDR_STS) ? sts_reg :
      (addr == DBC_ADDR_CNT) ? {56'h0, cnt_reg} :
      rd_rec ? rec_data : 64'h0;

   // Control next value: software first, hardware overrides
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_ctl) begin
         ctl_next = wdata & DBC_CTL_WMASK;
      end
      if (perf_rec) begin
         ctl_next[DBC_B_REC] = 1'b0;
      end
      if (dbg_fire) begin
         // Message enable is left alone on purpose
         ctl_next[DBC_B_REC] = 1'b0;
         ctl_next[DBC_B_STEP] = 1'b0;
      end
      if (mgmt_in) begin
         ctl_next = ctl_next & ~DBC_CTL_MGMT_CLR;
      end
      if (mgmt_out) begin
         ctl_next = save_reg;
      end
   end

   // Copy taken on entry, before the entry clears fields
   assign save_next = mgmt_in ? ctl_reg : save_reg;

   // Counter enables
   always_comb begin
      cnt_next = cnt_reg;
      if (wr_cnt) begin
         cnt_next = wdata[DBC_CNT_W-1:0];
      end
      if (perf_cnt || mgmt_in) begin
         cnt_next = DBC_CNT_RST;
      end
      if (mgmt_out) begin
         cnt_next = DBC_CNT_ONES;
      end
   end

   // Status: a cause arriving with a clear write still sets
   always_comb begin
      sts_next = sts_reg;
      if (wr_sts) begin
         sts_next = wdata & sts_reg;
      end
      if (tsw_pend_reg) begin
         sts_next[DBC_S_TSW] = 1'b1;
      end
      if (step_hit) begin
         sts_next[DBC_S_STEP] = 1'b1;
      end
   end

   // Freeze ends when software rewrites the control register
   always_comb begin
      frz_next = frz_reg;
      if (wr_ctl) begin
         frz_next = 1'b0;
      end
      if (perf_rec) begin
         frz_next = 1'b1;
      end
   end

   // Management mode state machine
   always_comb begin
      case (mode_reg)
         DBC_RUN: begin
            mode_next = mgmt_in ? DBC_MGMT : DBC_RUN;
         end
         DBC_MGMT: begin
            mode_next = mgmt_out ? DBC_RUN : DBC_MGMT;
         end
         default: begin
            mode_next = DBC_RUN;
         end
      endcase
   end

   // Output pulses for the processor
   always_comb begin
      evt_next = '0;
      evt_next.dbg_exc = dbg_fire;
      evt_next.cause_tsw = tsw_pend_reg;
      evt_next.cause_step = step_hit;
      evt_next.brk_exc = cpu.brk_insn;
      evt_next.trace_msg = msg_hit;
      evt_next.trace_store = store_hit;
      evt_next.buf_irq = full_irq;
   end

   assign rdata_next = re ? rd_mux : 64'h0;

   // Register state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_reg <= DBC_CTL_RST;
         sts_reg <= DBC_STS_RST;
         save_reg <= DBC_CTL_RST;
         cnt_reg <= DBC_CNT_RST;
         frz_reg <= 1'b0;
         mode_reg <= DBC_RUN;
      end else begin
         ctl_reg <= ctl_next;
         sts_reg <= sts_next;
         save_reg <= save_next;
         cnt_reg <= cnt_next;
         frz_reg <= frz_next;
         mode_reg <= mode_next;
      end
   end

   // Pulses, pending task exception and read data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         evt_reg <= '0;
         vec_reg <= 8'h00;
         tsw_pend_reg <= 1'b0;
         rdata_reg <= 64'h0;
      end else begin
         evt_reg <= evt_next;
         vec_reg <= cpu.brk_insn ? DBC_BRK_VEC : 8'h00;
         tsw_pend_reg <= tsw_hit;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign evt = evt_reg;
   assign brk_vector = vec_reg;
   assign counter_en = cnt_reg;
   assign debug_ctl = ctl_reg;

   // Checks
   sequence s_tsw;
      cpu.task_sw && cpu.task_trap;
   endsequence

   sequence s_tsw_exc;
      evt.dbg_exc && evt.cause_tsw;
   endsequence

   sequence s_resume;
      cpu.mgmt_mode_resume && mode_reg == DBC_MGMT;
   endsequence

   a_tsw_exc_raise: assert property (
      @(posedge clk) disable iff (!nrst)
      s_tsw |-> ##2 s_tsw_exc)
      else $error("task trap exception missing");

   a_tsw_status_set: assert property (
      @(posedge clk) disable iff (!nrst)
      s_tsw |-> ##2 sts_reg[DBC_S_TSW])
      else $error("task switch status not set");

   a_brk_vector_three: assert property (
      @(posedge clk) disable iff (!nrst)
      cpu.brk_insn |=> evt.brk_exc && brk_vector == 8'h03)
      else $error("breakpoint vector wrong");

   a_dbg_clear_bits: assert property (
      @(posedge clk) disable iff (!nrst)
      dbg_fire && !mgmt_out |=> !ctl_reg[0] && !ctl_reg[1])
      else $error("debug exception left enables set");

   a_dbg_keep_msg: assert property (
      @(posedge clk) disable iff (!nrst)
      dbg_fire && !wr_ctl && !mgmt_in && !mgmt_out
      |=> ctl_reg[6] == $past(ctl_reg[6]))
      else $error("debug exception changed message enable");

   a_no_dbg_record: assert property (
      @(posedge clk) disable iff (!nrst)
      cpu.exc && cpu.exc_is_dbg && !cpu.branch && !cpu.intr
      |-> !rec_push)
      else $error("debug exception recorded");

   a_skip_level_zero: assert property (
      @(posedge clk) disable iff (!nrst)
      ctl_reg[9] && cpu.current_privilege_level == 2'h0
      |=> !evt.trace_msg && !evt.trace_store)
      else $error("trace at level 0 not skipped");

   a_step_non_branch: assert property (
      @(posedge clk) disable iff (!nrst)
      ctl_reg[1] && cpu.trap_step_flag && cpu.retire && !cpu.branch
      |=> !evt.cause_step)
      else $error("branch step fired on non branch");

   a_perf_cnt_freeze: assert property (
      @(posedge clk) disable iff (!nrst)
      cpu.perf_irq && ctl_reg[12] && !mgmt_out
      |=> cnt_reg == 8'h00)
      else $error("counters not frozen");

   a_mgmt_restore: assert property (
      @(posedge clk) disable iff (!nrst)
      s_resume |=> ctl_reg == $past(save_reg) &&
                   cnt_reg == 8'hFF)
      else $error("resume did not restore");

   // Every recorded transfer moves the top of the stack on by one
   a_rec_push_tos: assert property (
      @(posedge clk) disable iff (!nrst)
      rec_push |=> rec_tos == $past(rec_tos) + 2'h1)
      else $error("record push did not advance");

   a_skip_level_user: assert property (
      @(posedge clk) disable iff (!nrst)
      ctl_reg[DBC_B_SKUSR] && cpu.current_privilege_level != 2'h0
      |=> !evt.trace_msg && !evt.trace_store)
      else $error("trace above level 0 not skipped");

   a_perf_rec_freeze: assert property (
      @(posedge clk) disable iff (!nrst)
      cpu.perf_irq && ctl_reg[DBC_B_FRZREC] && !mgmt_out
      |=> !ctl_reg[DBC_B_REC] && frz_reg)
      else $error("records not frozen");

   // Entry keeps the old value and leaves the four enables clear
   a_mgmt_entry_save: assert property (
      @(posedge clk) disable iff (!nrst)
      cpu.mgmt_irq && ctl_reg[DBC_B_MGMT] && mode_reg == DBC_RUN
      |=> save_reg == $past(ctl_reg) && cnt_reg == DBC_CNT_RST &&
          (ctl_reg & DBC_CTL_MGMT_CLR) == 64'h0)
      else $error("management entry not handled");
endmodule : dbc_ctrl

// ---- hdl/dbc_pkg.sv ----
package dbc_pkg;
   // Register addresses on the software port
   localparam logic [31:0] DBC_ADDR_CTL = 32'h000001D9;
   localparam logic [31:0] DBC_ADDR_STS = 32'h000001E0;
   localparam logic [31:0] DBC_ADDR_CNT = 32'h000001E1;
   localparam logic [31:0] DBC_ADDR_REC = 32'h000001E4;
   // Debug control field positions
   localparam int DBC_B_REC = 0;
   localparam int DBC_B_STEP = 1;
   localparam int DBC_B_MSG = 6;
   localparam int DBC_B_STORE = 7;
   localparam int DBC_B_IRQ = 8;
   localparam int DBC_B_SKPRIV = 9;
   localparam int DBC_B_SKUSR = 10;
   localparam int DBC_B_FRZREC = 11;
   localparam int DBC_B_FRZCNT = 12;
   localparam int DBC_B_MGMT = 14;
   // Implemented control bits; the rest read as zero
   localparam logic [63:0] DBC_CTL_WMASK = 64'h0000000000005FC3;
   localparam logic [63:0] DBC_CTL_RST = 64'h0000000000000000;
   // Fields cleared on management-mode entry
   localparam logic [63:0] DBC_CTL_MGMT_CLR = 64'h00000000000000C3;
   // Debug status cause bits
   localparam int DBC_S_STEP = 14;
   localparam int DBC_S_TSW = 15;
   localparam logic [63:0] DBC_STS_RST = 64'h0000000000000000;
   // Global counter enables
   localparam int DBC_CNT_W = 8;
   localparam logic [7:0] DBC_CNT_RST = 8'h00;
   localparam logic [7:0] DBC_CNT_ONES = 8'hFF;
   // Breakpoint vector and record depth
   localparam logic [7:0] DBC_BRK_VEC = 8'h03;
   localparam int DBC_REC_DEPTH = 4;

   // Management-mode state
   typedef enum logic [1:0] {
      DBC_RUN = 2'b01,
      DBC_MGMT = 2'b10
   } dbc_mode_t;

   // Events reported by the processor each cycle
   typedef struct packed {
      logic branch;        // Taken branch retired
      logic intr;          // Interrupt taken
      logic exc;           // Exception taken
      logic exc_is_dbg;    // That exception is a debug exception
      logic retire;        // Instruction retired
      logic task_sw;       // Task switch completed
      logic task_trap;     // New task's trap flag
      logic brk_insn;      // One-byte breakpoint instruction
      logic [1:0] current_privilege_level; // Privilege level
      logic trap_step_flag; // Trap-step flag
      logic perf_irq;      // Performance-monitor interrupt request
      logic mgmt_irq;      // Management-mode interrupt delivery
      logic mgmt_mode_resume; // Resume from management mode
      logic buf_full;      // Memory trace buffer full
      logic [31:0] from;   // Transfer source address
      logic [31:0] to;     // Transfer target address
   } dbc_cpu_t;

   // Exception and trace pulses back to the processor
   typedef struct packed {
      logic dbg_exc;       // Debug exception
      logic cause_tsw;     // Caused by task switch
      logic cause_step;    // Caused by single step
      logic brk_exc;       // Breakpoint exception
      logic trace_msg;     // Trace message on the system bus
      logic trace_store;   // Trace record to memory buffer
      logic buf_irq;       // Trace buffer full interrupt
   } dbc_evt_t;
endpackage : dbc_pkg

// ---- hdl/dbc_rec_stack.sv ----
`timescale 1ns/1ps
module dbc_rec_stack
   import dbc_pkg::*;
(
   input wire logic clk,           // Processor clock
   input wire logic nrst,          // Async reset, active low
   input wire logic push,          // Record one transfer
   input wire logic [31:0] from,   // Source address
   input wire logic [31:0] to,     // Target address
   input wire logic [1:0] rd_idx,  // Entry to read
   output logic [63:0] rd_data,    // Entry contents {to, from}
   output logic [1:0] tos          // Newest entry index
);
   logic [63:0] mem [DBC_REC_DEPTH]; // Ring of the last four transfers
   logic [1:0] tos_reg;              // Top of stack
   logic [1:0] tos_next;             // Slot for the next push

   assign tos_next = tos_reg + 2'h1;
   assign rd_data = mem[rd_idx];
   assign tos = tos_reg;

   // Oldest entry is overwritten; nothing here clears the ring
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tos_reg <= 2'h0;
      end else if (push) begin
         tos_reg <= tos_next;
      end
   end

   // Entries have no reset so the array maps onto plain storage
   genvar gi;
   for (gi = 0; gi < DBC_REC_DEPTH; gi++) begin : g_ent
      always_ff @(posedge clk) begin
         if (push && tos_next == 2'(gi)) begin
            mem[gi] <= {to, from};
         end
      end
   end
endmodule : dbc_rec_stack
